// ===== pefs_pkg.sv
// constants, register map and per-line routing tables for the port E function select
package pefs_pkg;

    localparam int          PEFS_NUM_LINES    = 7;
    localparam int          PEFS_REG_W        = 16;
    localparam int          PEFS_ADDR_W       = 4;
    localparam int          PEFS_ROUTE_W      = 5;

    // register addresses
    localparam logic [3:0]  PEFS_ADDR_SELECT_1 = 4'h0;
    localparam logic [3:0]  PEFS_ADDR_SELECT_2 = 4'h2;
    localparam logic [3:0]  PEFS_ADDR_STATUS   = 4'h4;

    localparam logic [15:0] PEFS_SELECT_RESET  = 16'h0000;

    // status register layout
    localparam int          PEFS_STATUS_DEBUG_BIT = 8;

    // two-bit function codes
    localparam logic [1:0]  PEFS_CODE_PORT = 2'h0;
    localparam logic [1:0]  PEFS_CODE_ALT1 = 2'h1;
    localparam logic [1:0]  PEFS_CODE_ALT2 = 2'h2;
    localparam logic [1:0]  PEFS_CODE_ALT3 = 2'h3;

    // one-hot route of a line
    localparam logic [4:0]  PEFS_ROUTE_PORT  = 5'h01;
    localparam logic [4:0]  PEFS_ROUTE_ALT1  = 5'h02;
    localparam logic [4:0]  PEFS_ROUTE_ALT2  = 5'h04;
    localparam logic [4:0]  PEFS_ROUTE_ALT3  = 5'h08;
    localparam logic [4:0]  PEFS_ROUTE_DEBUG = 5'h10;

    // entries: lines 0, 1, 2, 12, 13, 14, 15
    localparam int          PEFS_LINE_NUM [PEFS_NUM_LINES] = '{0, 1, 2, 12, 13, 14, 15};
    // field lsb inside its register
    localparam int          PEFS_FIELD_LSB [PEFS_NUM_LINES] = '{0, 2, 4, 8, 10, 12, 14};
    // field held in select_1 (else select_2); also marks second-variant lines
    localparam logic        PEFS_IN_SELECT_1 [PEFS_NUM_LINES] =
        '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    // bit k set: code k is a legal setting
    localparam logic [3:0]  PEFS_LEGAL [PEFS_NUM_LINES] =
        '{4'h7, 4'h7, 4'h7, 4'hB, 4'h7, 4'h7, 4'hF};
    // lines taken over by the debugger
    localparam logic        PEFS_DEBUG_LINE [PEFS_NUM_LINES] =
        '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

endpackage

// ===== pefs_line_decode.sv
// decode of one line's function field into a one-hot route
`timescale 1ns/1ps
module pefs_line_decode
    import pefs_pkg::*;
(
    input  wire logic [1:0] field_in,
    input  wire logic [3:0] legal_in,
    input  wire logic       enabled_in,
    input  wire logic       force_debug_in,
    output logic      [4:0] route_out,
    output logic            prohibited_out
);

    logic       code_legal;
    logic [4:0] decoded;

    assign code_legal = legal_in[field_in];

    assign decoded = (field_in == PEFS_CODE_ALT1) ? PEFS_ROUTE_ALT1 :
                     (field_in == PEFS_CODE_ALT2) ? PEFS_ROUTE_ALT2 :
                     (field_in == PEFS_CODE_ALT3) ? PEFS_ROUTE_ALT3 :
                                                    PEFS_ROUTE_PORT;

    // prohibited codes fall back to port mode
    assign route_out = !enabled_in    ? PEFS_ROUTE_PORT  :
                       force_debug_in ? PEFS_ROUTE_DEBUG :
                       !code_legal    ? PEFS_ROUTE_PORT  :
                                        decoded;

    assign prohibited_out = enabled_in & ~code_legal;

endmodule

// ===== pefs_port_e_function_select.sv
// port E function select: control registers, per-line routing and debug override
//
// Contract
// - line 2: port, timer 0C, DMA request 1
// - line 1: port, timer 0B, DMA acknowledge 0
// - line 0: port, timer 0A, DMA request 0
// - debug forces lines 2,1,0 to TDI,TRST,TMS
// - second variant debug forces line 12 to TCK
// - line 15: port, timer 4D, DMA_TRANSFER_ACK_1, IRQ out
// - line 14: port, timer 4C, DMA acknowledge 0
// - line 13: port, timer 4B, manual reset
// - line 12: port, timer 4A, serial 3 transmit
`timescale 1ns/1ps
module pefs_port_e_function_select
    import pefs_pkg::*;
#(
    parameter logic SECOND_VARIANT = 1'b1,
    parameter logic FLASH_VERSION  = 1'b1
)
(
    input  wire logic                   ref_clk_in,
    input  wire logic                   sys_rst_in,
    input  wire logic [PEFS_ADDR_W-1:0] reg_addr_in,
    input  wire logic [PEFS_REG_W-1:0]  reg_wdata_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    output logic      [PEFS_REG_W-1:0]  reg_rdata_out,
    input  wire logic                   debug_mode_input_in,
    input  wire logic                   debugger_in_use_in,
    output logic                        debug_override_out,
    output logic      [4:0]             line0_route_out,
    output logic      [4:0]             line1_route_out,
    output logic      [4:0]             line2_route_out,
    output logic      [4:0]             line12_route_out,
    output logic      [4:0]             line13_route_out,
    output logic      [4:0]             line14_route_out,
    output logic      [4:0]             line15_route_out
);

    logic [PEFS_REG_W-1:0]   select_1_r;
    logic [PEFS_REG_W-1:0]   select_2_r;
    logic [PEFS_REG_W-1:0]   reg_rdata_r;
    logic [PEFS_REG_W-1:0]   rd_mux;
    logic [PEFS_REG_W-1:0]   status_w;
    logic                    wr_select_1;
    logic                    wr_select_2;
    logic                    force_now;
    logic                    debug_override_r;
    logic [4:0]              route_nxt   [PEFS_NUM_LINES];
    logic [4:0]              line_route_r[PEFS_NUM_LINES];
    logic [1:0]              field_w     [PEFS_NUM_LINES];
    logic [PEFS_NUM_LINES-1:0] prohibited_w;

    // register bus decode
    assign wr_select_1 = reg_wr_in && (reg_addr_in == PEFS_ADDR_SELECT_1);
    assign wr_select_2 = reg_wr_in && (reg_addr_in == PEFS_ADDR_SELECT_2);

    // debugger takeover only exists on the flash build
    assign force_now = debug_mode_input_in & debugger_in_use_in & FLASH_VERSION;

    always_comb begin
        status_w = '0;
        status_w[PEFS_NUM_LINES-1:0] = prohibited_w;
        status_w[PEFS_STATUS_DEBUG_BIT] = debug_override_r;
    end

    assign rd_mux = (reg_addr_in == PEFS_ADDR_SELECT_1) ? select_1_r :
                    (reg_addr_in == PEFS_ADDR_SELECT_2) ? select_2_r :
                    (reg_addr_in == PEFS_ADDR_STATUS)   ? status_w   :
                                                          '0;

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            select_1_r <= PEFS_SELECT_RESET;
        end else if (wr_select_1) begin
            select_1_r <= reg_wdata_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            select_2_r <= PEFS_SELECT_RESET;
        end else if (wr_select_2) begin
            select_2_r <= reg_wdata_in;
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            reg_rdata_r <= '0;
        end else if (reg_rd_in) begin
            reg_rdata_r <= rd_mux;
        end else begin
            reg_rdata_r <= '0;
        end
    end

    // per-line field extraction and decode
    generate
        for (genvar i = 0; i < PEFS_NUM_LINES; i++) begin : g_line
            localparam logic SECOND_ONLY = PEFS_IN_SELECT_1[i];
            logic enabled;
            logic force_line;

            assign field_w[i] = SECOND_ONLY ?
                select_1_r[PEFS_FIELD_LSB[i] +: 2] :
                select_2_r[PEFS_FIELD_LSB[i] +: 2];
            assign enabled    = !SECOND_ONLY || SECOND_VARIANT;
            assign force_line = force_now && PEFS_DEBUG_LINE[i];

            pefs_line_decode u_decode (
                .field_in       (field_w[i]),
                .legal_in       (PEFS_LEGAL[i]),
                .enabled_in     (enabled),
                .force_debug_in (force_line),
                .route_out      (route_nxt[i]),
                .prohibited_out (prohibited_w[i])
            );

            always_ff @(posedge ref_clk_in) begin
                if (sys_rst_in) begin
                    line_route_r[i] <= PEFS_ROUTE_PORT;
                end else begin
                    line_route_r[i] <= route_nxt[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            debug_override_r <= 1'b0;
        end else begin
            debug_override_r <= force_now;
        end
    end

    assign reg_rdata_out      = reg_rdata_r;
    assign debug_override_out = debug_override_r;
    assign line0_route_out    = line_route_r[0];
    assign line1_route_out    = line_route_r[1];
    assign line2_route_out    = line_route_r[2];
    assign line12_route_out   = line_route_r[3];
    assign line13_route_out   = line_route_r[4];
    assign line14_route_out   = line_route_r[5];
    assign line15_route_out   = line_route_r[6];

    // checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_write_sel2;
        wr_select_2;
    endsequence

    sequence s_read_sel2;
        reg_rd_in && (reg_addr_in == PEFS_ADDR_SELECT_2);
    endsequence

    fields_reset_a: assert property (
        $past(sys_rst_in) |-> (select_1_r == PEFS_SELECT_RESET) &&
                              (select_2_r == PEFS_SELECT_RESET) &&
                              (line_route_r[2] == PEFS_ROUTE_PORT))
        else $error("select fields not at reset value");

    sel2_readback_a: assert property (
        s_write_sel2 ##1 s_read_sel2 |=> reg_rdata_out == $past(reg_wdata_in, 2))
        else $error("select_2 readback mismatch");

    line2_dma_a: assert property (
        (field_w[2] == PEFS_CODE_ALT2) && !force_now |=> line2_route_out == PEFS_ROUTE_ALT2)
        else $error("line 2 not routed to DMA request");

    line1_dma_a: assert property (
        (field_w[1] == PEFS_CODE_ALT2) && !force_now |=> line1_route_out == PEFS_ROUTE_ALT2)
        else $error("line 1 not routed to DMA acknowledge");

    line0_timer_a: assert property (
        (field_w[0] == PEFS_CODE_ALT1) && !force_now |=> line0_route_out == PEFS_ROUTE_ALT1)
        else $error("line 0 not routed to timer");

    debug_low_lines_a: assert property (
        force_now |=> (line0_route_out == PEFS_ROUTE_DEBUG) &&
                      (line1_route_out == PEFS_ROUTE_DEBUG) &&
                      (line2_route_out == PEFS_ROUTE_DEBUG) && debug_override_out)
        else $error("debug override missing on low lines");

    debug_line12_a: assert property (
        force_now && SECOND_VARIANT |=> line12_route_out == PEFS_ROUTE_DEBUG)
        else $error("line 12 not forced to debug clock");

    line15_irq_a: assert property (
        (field_w[6] == PEFS_CODE_ALT3) && SECOND_VARIANT
            |=> line15_route_out == PEFS_ROUTE_ALT3)
        else $error("line 15 not routed to interrupt request");

    line14_dack_a: assert property (
        (field_w[5] == PEFS_CODE_ALT2) && SECOND_VARIANT
            |=> line14_route_out == PEFS_ROUTE_ALT2)
        else $error("line 14 not routed to DMA acknowledge");

    line13_timer_a: assert property (
        (field_w[4] == PEFS_CODE_ALT1) && SECOND_VARIANT
            |=> line13_route_out == PEFS_ROUTE_ALT1)
        else $error("line 13 not routed to timer");

    line12_serial_a: assert property (
        (field_w[3] == PEFS_CODE_ALT3) && SECOND_VARIANT && !force_now
            |=> line12_route_out == PEFS_ROUTE_ALT3)
        else $error("line 12 not routed to serial transmit");

    debug_release_a: assert property (
        !force_now ##1 !force_now |-> !debug_override_out &&
                                      (line0_route_out != PEFS_ROUTE_DEBUG))
        else $error("debug override held without cause");

    // further bus and routing checks
    sequence s_write_sel1;
        wr_select_1;
    endsequence

    sequence s_write_status;
        reg_wr_in && (reg_addr_in == PEFS_ADDR_STATUS);
    endsequence

    sequence s_read_status;
        reg_rd_in && (reg_addr_in == PEFS_ADDR_STATUS);
    endsequence

    sequence s_read_unmapped;
        reg_rd_in && (reg_addr_in != PEFS_ADDR_SELECT_1) &&
        (reg_addr_in != PEFS_ADDR_SELECT_2) && (reg_addr_in != PEFS_ADDR_STATUS);
    endsequence

    sequence s_debug_held;
        force_now ##1 force_now;
    endsequence

    sel1_write_a: assert property (
        s_write_sel1 |=> select_1_r == $past(reg_wdata_in))
        else $error("select_1 write lost");

    status_readonly_a: assert property (
        s_write_status |=> $stable(select_1_r) && $stable(select_2_r))
        else $error("status write changed a select register");

    status_debug_a: assert property (
        s_read_status |=> reg_rdata_out[PEFS_STATUS_DEBUG_BIT] == $past(debug_override_out))
        else $error("status debug bit mismatch");

    unmapped_read_a: assert property (
        s_read_unmapped |=> reg_rdata_out == '0)
        else $error("unmapped read returned data");

    rdata_idle_a: assert property (
        !reg_rd_in |=> reg_rdata_out == '0)
        else $error("read data held past its cycle");

    debug_hold_a: assert property (
        s_debug_held |-> debug_override_out && (line1_route_out == PEFS_ROUTE_DEBUG))
        else $error("debug override dropped while held");

    line0_dma_a: assert property (
        (field_w[0] == PEFS_CODE_ALT2) && !force_now |=> line0_route_out == PEFS_ROUTE_ALT2)
        else $error("line 0 not routed to DMA request");

    line0_port_a: assert property (
        (field_w[0] == PEFS_CODE_PORT) && !force_now |=> line0_route_out == PEFS_ROUTE_PORT)
        else $error("line 0 not in port mode");

    line1_timer_a: assert property (
        (field_w[1] == PEFS_CODE_ALT1) && !force_now |=> line1_route_out == PEFS_ROUTE_ALT1)
        else $error("line 1 not routed to timer");

    line2_timer_a: assert property (
        (field_w[2] == PEFS_CODE_ALT1) && !force_now |=> line2_route_out == PEFS_ROUTE_ALT1)
        else $error("line 2 not routed to timer");

    line15_dack_a: assert property (
        (field_w[6] == PEFS_CODE_ALT2) && SECOND_VARIANT
            |=> line15_route_out == PEFS_ROUTE_ALT2)
        else $error("line 15 not routed to DMA acknowledge");

    line15_timer_a: assert property (
        (field_w[6] == PEFS_CODE_ALT1) && SECOND_VARIANT
            |=> line15_route_out == PEFS_ROUTE_ALT1)
        else $error("line 15 not routed to timer");

    line14_timer_a: assert property (
        (field_w[5] == PEFS_CODE_ALT1) && SECOND_VARIANT
            |=> line14_route_out == PEFS_ROUTE_ALT1)
        else $error("line 14 not routed to timer");

    line13_reset_a: assert property (
        (field_w[4] == PEFS_CODE_ALT2) && SECOND_VARIANT
            |=> line13_route_out == PEFS_ROUTE_ALT2)
        else $error("line 13 not routed to manual reset");

    line12_timer_a: assert property (
        (field_w[3] == PEFS_CODE_ALT1) && SECOND_VARIANT && !force_now
            |=> line12_route_out == PEFS_ROUTE_ALT1)
        else $error("line 12 not routed to timer");

    variant_off_a: assert property (
        !SECOND_VARIANT |=> (line12_route_out == PEFS_ROUTE_PORT) &&
                            (line13_route_out == PEFS_ROUTE_PORT) &&
                            (line14_route_out == PEFS_ROUTE_PORT) &&
                            (line15_route_out == PEFS_ROUTE_PORT))
        else $error("first variant drives an upper line");

endmodule

// ===== pefs_dbg_pod_model.sv
// debugger pod model driving the debug-mode pin and in-use line
`timescale 1ns/1ps
module pefs_dbg_pod_model (
    input  wire logic ref_clk_in,
    input  wire logic attach_in,
    input  wire logic flash_in,
    output logic      debug_mode_out,
    output logic      in_use_out
);
    // only attaches to a flash part
    always @(posedge ref_clk_in) begin
        debug_mode_out <= attach_in & flash_in;
        in_use_out     <= attach_in & flash_in;
    end
endmodule

// ===== tb_top.sv
// self-checking bench for the port E function select
`timescale 1ns/1ps
module tb_top;
    import pefs_pkg::*;
    logic        ref_clk_in   = 1'b0;
    logic        sys_rst_in   = 1'b1;
    logic [3:0]  reg_addr_in  = 4'h0;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic        reg_wr_in    = 1'b0;
    logic        reg_rd_in    = 1'b0;
    logic        attach       = 1'b0;
    logic        rd_d         = 1'b0;
    wire  [15:0] rdata;
    wire         dbg_mode;
    wire         dbg_use;
    wire         override;
    wire  [4:0]  route [PEFS_NUM_LINES];
    wire         override_v1;
    wire  [4:0]  route_v1 [PEFS_NUM_LINES];
    logic [15:0] exp_q [$];
    logic [1:0]  code [PEFS_NUM_LINES];
    logic [15:0] s1;
    logic [15:0] s2;
    int          n_mismatch   = 0;
    int          checks_done  = 0;
    int          cycles       = 0;

    always #20 ref_clk_in = ~ref_clk_in;

    pefs_dbg_pod_model pefs_dbg_pod_model_inst (
        .ref_clk_in     (ref_clk_in),
        .attach_in      (attach),
        .flash_in       (1'b1),
        .debug_mode_out (dbg_mode),
        .in_use_out     (dbg_use)
    );

    pefs_port_e_function_select pefs_port_e_function_select_inst (
        .ref_clk_in          (ref_clk_in),
        .sys_rst_in          (sys_rst_in),
        .reg_addr_in         (reg_addr_in),
        .reg_wdata_in        (reg_wdata_in),
        .reg_wr_in           (reg_wr_in),
        .reg_rd_in           (reg_rd_in),
        .reg_rdata_out       (rdata),
        .debug_mode_input_in (dbg_mode),
        .debugger_in_use_in  (dbg_use),
        .debug_override_out  (override),
        .line0_route_out     (route[0]),
        .line1_route_out     (route[1]),
        .line2_route_out     (route[2]),
        .line12_route_out    (route[3]),
        .line13_route_out    (route[4]),
        .line14_route_out    (route[5]),
        .line15_route_out    (route[6])
    );

    // first package variant: upper lines stay in port mode
    pefs_port_e_function_select #(
        .SECOND_VARIANT (1'b0),
        .FLASH_VERSION  (1'b1)
    ) pefs_port_e_function_select_v1_inst (
        .ref_clk_in          (ref_clk_in),
        .sys_rst_in          (sys_rst_in),
        .reg_addr_in         (reg_addr_in),
        .reg_wdata_in        (reg_wdata_in),
        .reg_wr_in           (reg_wr_in),
        .reg_rd_in           (reg_rd_in),
        .reg_rdata_out       (),
        .debug_mode_input_in (dbg_mode),
        .debugger_in_use_in  (dbg_use),
        .debug_override_out  (override_v1),
        .line0_route_out     (route_v1[0]),
        .line1_route_out     (route_v1[1]),
        .line2_route_out     (route_v1[2]),
        .line12_route_out    (route_v1[3]),
        .line13_route_out    (route_v1[4]),
        .line14_route_out    (route_v1[5]),
        .line15_route_out    (route_v1[6])
    );

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        reg_rd_in    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wr_in   <= 1'b0;
        reg_rd_in   <= 1'b1;
        exp_q.push_back(e);
    endtask

    task automatic idle(input int n);
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        repeat (n) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
    endtask

    task automatic check_routes(input logic dbg);
        logic [4:0] e;
        for (int j = 0; j < PEFS_NUM_LINES; j++) begin
            e = 5'h01 << code[j];
            if (dbg && PEFS_DEBUG_LINE[j]) begin
                e = 5'h10;
            end
            check($sformatf("route %0d", PEFS_LINE_NUM[j]), 16'(route[j]), 16'(e));
            if (PEFS_IN_SELECT_1[j]) begin
                e = 5'h01;
            end
            check($sformatf("v1 route %0d", PEFS_LINE_NUM[j]), 16'(route_v1[j]), 16'(e));
        end
        check("override", 16'(override), 16'(dbg));
        check("v1 override", 16'(override_v1), 16'(dbg));
    endtask

    // unrelated fields get random storage values
    task automatic set_codes();
        s1 = 16'($urandom) & 16'h00FF;
        s2 = 16'($urandom) & 16'hFFC0;
        for (int j = 0; j < PEFS_NUM_LINES; j++) begin
            if (PEFS_IN_SELECT_1[j]) begin
                s1[PEFS_FIELD_LSB[j] +: 2] = code[j];
            end else begin
                s2[PEFS_FIELD_LSB[j] +: 2] = code[j];
            end
        end
        wr(PEFS_ADDR_SELECT_1, s1);
        wr(PEFS_ADDR_SELECT_2, s2);
        rd(PEFS_ADDR_SELECT_2, s2);
        rd(PEFS_ADDR_SELECT_1, s1);
        idle(2);
    endtask

    // hold reset for n edges, then read back and check the cleared state
    task automatic reset_test(input int n);
        sys_rst_in <= 1'b1;
        code = '{default: 2'h0};
        repeat (n) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        rd(PEFS_ADDR_SELECT_1, PEFS_SELECT_RESET);
        rd(PEFS_ADDR_SELECT_2, PEFS_SELECT_RESET);
        idle(1);
        check_routes(1'b0);
        $display("test reset done");
    endtask

    always @(posedge ref_clk_in) begin
        rd_d <= reg_rd_in;
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    always @(negedge ref_clk_in) begin
        if (rd_d) begin
            check("read data", rdata, exp_q.pop_front());
        end
    end

    initial begin
        void'($urandom(32'h0A7F807D));
        reset_test(5);
        // first four passes sweep each code, the rest mix codes per line
        for (int i = 0; i < 12; i++) begin
            for (int j = 0; j < PEFS_NUM_LINES; j++) begin
                code[j] = (i < 4) ? 2'(i) : 2'($urandom);
                while (!PEFS_LEGAL[j][code[j]]) begin
                    code[j] = 2'($urandom);
                end
            end
            set_codes();
            check_routes(1'b0);
        end
        $display("test codes done");
        @(posedge ref_clk_in);
        attach <= 1'b1;
        idle(2);
        check_routes(1'b1);
        rd(PEFS_ADDR_STATUS, 16'h0001 << PEFS_STATUS_DEBUG_BIT);
        wr(PEFS_ADDR_STATUS, 16'hFFFF);
        wr(4'hE, 16'hFFFF);
        rd(PEFS_ADDR_STATUS, 16'h0001 << PEFS_STATUS_DEBUG_BIT);
        rd(4'hE, 16'h0000);
        rd(PEFS_ADDR_SELECT_1, s1);
        idle(1);
        @(posedge ref_clk_in);
        attach <= 1'b0;
        idle(2);
        check_routes(1'b0);
        $display("test debug done");
        // mid-run reset with non-zero fields in place
        @(posedge ref_clk_in);
        reset_test(3);
        tally_and_finish();
    end
endmodule
